// ---- design/rgmii_port_defs.svh ----
`ifndef RGMII_PORT_DEFS_SVH
`define RGMII_PORT_DEFS_SVH

// system clock rate in Hz
`define SYS_CLK_HZ      20000000
// transmit clock rates per speed in Hz
`define TXCLK_1000_HZ   125000000
`define TXCLK_100_HZ    25000000
`define TXCLK_10_HZ     2500000
// half periods of the transmit clock in system cycles, rounded down
`define TXHALF_1000     (`SYS_CLK_HZ / (2 * `TXCLK_1000_HZ))
`define TXHALF_100      (`SYS_CLK_HZ / (2 * `TXCLK_100_HZ))
`define TXHALF_10       (`SYS_CLK_HZ / (2 * `TXCLK_10_HZ))
// cycles after reset release before the strap pin level is taken
`define STRAP_WAIT      5'h10
// reference clock select value taken until the strap is read (0 = 25 MHz)
`define REFCLK_SEL_RST  1'b0

`endif

// ---- design/rgmii_port_pkg.sv ----
`default_nettype none

package rgmii_port_pkg;

  typedef enum logic [1:0] {
    SPEED_10   = 2'b00,
    SPEED_100  = 2'b01,
    SPEED_1000 = 2'b10
  } speed_t;

  typedef enum logic [1:0] {
    TX_FIRST  = 2'b00,
    TX_SECOND = 2'b01
  } tx_phase_t;

endpackage : rgmii_port_pkg

`default_nettype wire

// ---- design/two_entry_buffer.sv ----
`timescale 1ns/100ps
`default_nettype none

module two_entry_buffer
(
  input  wire logic       clk,
  input  wire logic       rst,
  input  wire logic       inValid,
  input  wire logic [7:0] inData,
  output logic            inReady,
  output logic            outValid,
  output logic      [7:0] outData,
  input  wire logic       outReady
);

  typedef struct packed {
    logic [1:0][7:0] entry;
    logic            wrPtr;
    logic            rdPtr;
    logic [1:0]      count;
  } buf_state_t;

  buf_state_t s;
  buf_state_t next_s;

  // full and empty come straight from the count, so neither side is lied to
  assign inReady  = (s.count != 2'h2);
  assign outValid = (s.count != 2'h0);
  assign outData  = s.entry[s.rdPtr];

  // push and pop may happen in the same cycle
  always_comb
  begin
    next_s = s;
    if (inValid && inReady)
    begin
      next_s.entry[s.wrPtr] = inData;
      next_s.wrPtr          = ~s.wrPtr;
    end
    if (outValid && outReady)
      next_s.rdPtr = ~s.rdPtr;
    case ({inValid && inReady, outValid && outReady})
      2'b10:   next_s.count = s.count + 2'h1;
      2'b01:   next_s.count = s.count - 2'h1;
      default: next_s.count = s.count;
    endcase
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      s <= '0;
    else
      s <= next_s;
  end

endmodule : two_entry_buffer

`default_nettype wire

// ---- design/rgmii_port_pins.sv ----
//Behaviour
//RULE1 - reference clock may be 25 or 50 MHz, chosen by the strap level
//RULE2 - strap level is read from the lamp five pin, not a dedicated input
//RULE3 - partner supplies management receive clock at 125, 25 or 2.5 MHz
//RULE4 - gigabit receive: bits 3..0 on rising edge, bits 7..4 on falling edge
//RULE5 - 10/100 receive: only bits 3..0, sampled on rising receive clock edge
//RULE6 - management receive valid is active high and qualifies the nibble
//RULE7 - partner drives receive valid from its own transmit enable
//RULE8 - device drives management transmit clock at 125, 25 or 2.5 MHz; code gives 10 MHz (sys_clk/2) at 1000 and 100
//RULE9 - gigabit transmit: bits 3..0 on rising edge, bits 7..4 on falling edge
//RULE10 - 10/100 transmit: only bits 3..0, launched on rising transmit edge
//RULE11 - partner supplies uplink receive clock at 125, 25 or 2.5 MHz
//RULE12 - uplink receive valid qualifies the four uplink receive data inputs
//RULE13 - lamp select 0: shared uplink pin carries the transmit clock
//RULE14 - lamp select 1: shared uplink pin carries lamp 15, active low
//RULE15 - transmit enable high exactly while valid frame data is presented
`include "rgmii_port_defs.svh"
`timescale 1ns/100ps
`default_nettype none

module rgmii_port_pins
(
  input  wire logic                 sys_clk,
  input  wire logic                 rst,
  input  wire rgmii_port_pkg::speed_t speedMode,
  input  wire logic                 mgmtPortRxClock,
  input  wire logic [3:0]           mgmtPortRxData,
  input  wire logic                 mgmtPortRxValid,
  output logic                      mgmtPortTxClock,
  output logic      [3:0]           mgmtPortTxData,
  output logic                      mgmtPortTxEnable,
  output logic      [7:0]           rxByte,
  output logic                      rxByteValid,
  input  wire logic                 rxByteReady,
  output logic                      rxOverrun,
  input  wire logic [7:0]           txByte,
  input  wire logic                 txByteValid,
  output logic                      txByteReady,
  input  wire logic                 uplinkRxClock,
  input  wire logic [3:0]           uplinkRxData,
  input  wire logic                 uplinkRxValid,
  output logic      [3:0]           uplinkRxNibble,
  output logic                      uplinkRxNibbleValid,
  input  wire logic                 uplinkLampSelect,
  input  wire logic                 lampFifteenOn,
  output logic                      uplinkTxClockOrLamp,
  input  wire logic                 lampFiveOn,
  input  wire logic                 lampFiveIn,
  output logic                      lampFiveOut,
  output logic                      lampFiveOe,
  output logic                      refclkFreqStrap
);

  import rgmii_port_pkg::*;

  typedef struct packed {
    logic [2:0]      mClkSync;
    logic [2:0]      mDvSync;
    logic [2:0][3:0] mDataSync;
    logic            mClkLvl;
    logic [2:0]      uClkSync;
    logic [2:0]      uDvSync;
    logic [2:0][3:0] uDataSync;
    logic            uClkLvl;
    logic [3:0]      uNibble;
    logic            uNibbleValid;
    logic [3:0]      rxLo;
    logic            rxHave;
    logic            pushValid;
    logic [7:0]      pushData;
    logic            overrun;
    logic [5:0]      divCnt;
    logic            txClk;
    tx_phase_t       txPhase;
    logic [3:0]      txHi;
    logic [3:0]      txNib;
    logic            txEn;
    logic            uOut;
    logic [2:0]      strapSync;
    logic [4:0]      strapCnt;
    logic            strapDone;
    logic            refclk50;
    logic            lampOut;
  } pins_state_t;

  pins_state_t s;
  pins_state_t next_s;
  logic        bufInReady;
  logic        mRise;
  logic        mFall;
  logic        uRise;
  logic        uFall;
  logic        txRise;
  logic        txFall;
  logic        txTake;

  // an edge counts once stages two and three agree on a level new to us
  function automatic logic [1:0] edgeOf(input logic [2:0] sync, input logic lvl);
    logic [1:0] r;
    r = 2'h0;
    if ((sync[1] == sync[2]) && (sync[2] != lvl))
      r = {sync[2], ~sync[2]};
    return r;
  endfunction : edgeOf

  // half period in system cycles; rates above sys_clk/2 clamp to one cycle
  function automatic logic [5:0] halfCount(input speed_t sp);
    int h;
    case (sp)
      SPEED_1000: h = `TXHALF_1000;
      SPEED_100:  h = `TXHALF_100;
      default:    h = `TXHALF_10;
    endcase
    if (h < 1)
      h = 1;
    return h[5:0];
  endfunction : halfCount

  // received bytes wait here, two deep, so a consumer stalled for up to two bytes does not lose a word
  two_entry_buffer rxBuffer
  (
    .clk      (sys_clk),
    .rst      (rst),
    .inValid  (s.pushValid),
    .inData   (s.pushData),
    .inReady  (bufInReady),
    .outValid (rxByteValid),
    .outData  (rxByte),
    .outReady (rxByteReady)
  );

  // edge events and the transmit handshake
  assign {mRise, mFall} = edgeOf(s.mClkSync, s.mClkLvl);
  assign {uRise, uFall} = edgeOf(s.uClkSync, s.uClkLvl);
  assign txRise      = (s.divCnt <= 6'h01) && !s.txClk;
  assign txFall      = (s.divCnt <= 6'h01) && s.txClk;
  assign txTake      = txRise && txByteValid &&
                       ((speedMode == SPEED_1000) || (s.txPhase == TX_FIRST));
  assign txByteReady = txTake;

  always_comb
  begin
    next_s = s;
    // three-stage synchronisers; stage one feeds only stage two
    next_s.mClkSync  = {s.mClkSync[1:0], mgmtPortRxClock};
    next_s.mDvSync   = {s.mDvSync[1:0], mgmtPortRxValid};
    next_s.mDataSync = {s.mDataSync[1:0], mgmtPortRxData};
    next_s.uClkSync  = {s.uClkSync[1:0], uplinkRxClock};
    next_s.uDvSync   = {s.uDvSync[1:0], uplinkRxValid};
    next_s.uDataSync = {s.uDataSync[1:0], uplinkRxData};
    next_s.strapSync = {s.strapSync[1:0], lampFiveIn};
    if (mRise || mFall)
      next_s.mClkLvl = mRise;
    if (uRise || uFall)
      next_s.uClkLvl = uRise;

    // management receive: nibbles paired into bytes, low nibble first
    next_s.pushValid = 1'b0;
    next_s.overrun   = s.pushValid && !bufInReady; // link cannot stall, so report
    if (speedMode == SPEED_1000)
    begin
      if (mRise)
      begin
        next_s.rxHave = s.mDvSync[2]; // [RULE6]
        next_s.rxLo   = s.mDataSync[2]; // [RULE4]
      end
      else if (mFall && s.rxHave)
      begin
        next_s.pushValid = 1'b1;
        next_s.pushData  = {s.mDataSync[2], s.rxLo}; // [RULE4]
        next_s.rxHave    = 1'b0;
      end
    end
    else if (mRise)
    begin
      if (!s.mDvSync[2])
        next_s.rxHave = 1'b0; // odd nibble at frame end is dropped [RULE6]
      else if (!s.rxHave)
      begin
        next_s.rxLo   = s.mDataSync[2]; // [RULE5]
        next_s.rxHave = 1'b1;
      end
      else
      begin
        next_s.pushValid = 1'b1;
        next_s.pushData  = {s.mDataSync[2], s.rxLo}; // [RULE5]
        next_s.rxHave    = 1'b0;
      end
    end

    // uplink receive: each valid nibble on a rising edge is passed on
    next_s.uNibbleValid = uRise && s.uDvSync[2]; // [RULE12]
    if (uRise && s.uDvSync[2])
      next_s.uNibble = s.uDataSync[2]; // [RULE12]

    // transmit clock divider; true rate only where sys_clk allows it
    if (s.divCnt <= 6'h01)
    begin
      next_s.txClk  = ~s.txClk; // [RULE8]
      next_s.divCnt = halfCount(speedMode); // [RULE8]
    end
    else
      next_s.divCnt = s.divCnt - 6'h01;

    // transmit launch on the same edge that the clock output changes
    if (txRise)
    begin
      if ((speedMode != SPEED_1000) && (s.txPhase == TX_SECOND))
      begin
        next_s.txNib   = s.txHi; // [RULE10]
        next_s.txPhase = TX_FIRST;
      end
      else if (txTake)
      begin
        next_s.txNib   = txByte[3:0]; // [RULE9] [RULE10]
        next_s.txHi    = txByte[7:4];
        next_s.txEn    = 1'b1; // [RULE15]
        next_s.txPhase = (speedMode == SPEED_1000) ? TX_FIRST : TX_SECOND;
      end
      else
        next_s.txEn = 1'b0; // [RULE15]
    end
    else if (txFall && (speedMode == SPEED_1000) && s.txEn)
      next_s.txNib = s.txHi; // [RULE9]

    // shared uplink pin: transmit clock or inverted lamp
    next_s.uOut = uplinkLampSelect ? ~lampFifteenOn : next_s.txClk; // [RULE13] [RULE14]

    // strap: pin left undriven until its level has been taken
    if (!s.strapDone)
    begin
      if (s.strapCnt == `STRAP_WAIT)
      begin
        next_s.refclk50  = s.strapSync[2]; // [RULE1] [RULE2]
        next_s.strapDone = 1'b1;
      end
      else
        next_s.strapCnt = s.strapCnt + 5'h01;
    end
    next_s.lampOut = ~lampFiveOn; // lamp is active low once released
  end

  // reset holds every flag clear and the strap at its default choice
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      s          <= '0;
      s.refclk50 <= `REFCLK_SEL_RST;
    end
    else
      s <= next_s;
  end

  // all link-facing data outputs come from flops
  assign mgmtPortTxClock     = s.txClk;
  assign mgmtPortTxData      = s.txNib;
  assign mgmtPortTxEnable    = s.txEn;
  assign rxOverrun           = s.overrun;
  assign uplinkRxNibble      = s.uNibble;
  assign uplinkRxNibbleValid = s.uNibbleValid;
  assign uplinkTxClockOrLamp = s.uOut;
  assign lampFiveOut         = s.lampOut;
  assign lampFiveOe          = s.strapDone; // [RULE2]
  assign refclkFreqStrap     = s.refclk50;

endmodule : rgmii_port_pins

`default_nettype wire

// ---- verif/rgmii_port_pins_checker.sv ----
`timescale 1ns/100ps
`default_nettype none

module rgmii_port_pins_checker
(
  input wire logic       sys_clk,
  input wire logic       rst,
  input wire rgmii_port_pkg::speed_t speedMode,
  input wire logic       mgmtPortTxClock,
  input wire logic [3:0] mgmtPortTxData,
  input wire logic       mgmtPortTxEnable,
  input wire logic [7:0] rxByte,
  input wire logic       rxByteValid,
  input wire logic       rxByteReady,
  input wire logic [7:0] txByte,
  input wire logic       txByteValid,
  input wire logic       txByteReady,
  input wire logic       uplinkRxNibbleValid,
  input wire logic       uplinkLampSelect,
  input wire logic       lampFifteenOn,
  input wire logic       uplinkTxClockOrLamp,
  input wire logic       lampFiveOn,
  input wire logic       lampFiveIn,
  input wire logic       lampFiveOut,
  input wire logic       lampFiveOe,
  input wire logic       refclkFreqStrap
);
  import rgmii_port_pkg::*;

  logic [4:0] sinceReset;

  // cycles since reset release; saturates so a long run never wraps back to the strap slot
  always_ff @(posedge sys_clk or posedge rst)
    if (rst)
      sinceReset <= 5'h00;
    else if (sinceReset != 5'h1F)
      sinceReset <= sinceReset + 5'h01;

  default clocking @(posedge sys_clk); endclocking
  default disable iff (rst);

  a_strap_capture: assert property ($rose(lampFiveOe) |->
    sinceReset == 5'h11 && refclkFreqStrap == $past(lampFiveIn)) else $error("strap late or wrong");
  a_lamp_five: assert property (lampFiveOe |-> lampFiveOut == !$past(lampFiveOn))
    else $error("lamp five level wrong");
  a_tx_take: assert property (txByteValid && txByteReady |=>
    mgmtPortTxEnable && mgmtPortTxClock && mgmtPortTxData == $past(txByte[3:0]))
    else $error("low nibble not launched");
  a_gig_high: assert property (speedMode == SPEED_1000 && txByteValid && txByteReady |->
    ##2 !mgmtPortTxClock && mgmtPortTxData == $past(txByte[7:4], 2)) else $error("gig high nibble");
  a_slow_hold: assert property (speedMode != SPEED_1000 && !$rose(mgmtPortTxClock) |->
    $stable(mgmtPortTxData)) else $error("tx data moved off rising edge");
  a_slow_rate: assert property (speedMode == SPEED_10 && $rose(mgmtPortTxClock) |->
    mgmtPortTxClock [*4] ##1 !mgmtPortTxClock [*4]) else $error("10M tx clock period");
  a_fast_rate: assert property (speedMode != SPEED_10 && $rose(mgmtPortTxClock) |=>
    !mgmtPortTxClock ##1 mgmtPortTxClock) else $error("fast tx clock period");
  a_rx_stands: assert property (rxByteValid && !rxByteReady |=>
    rxByteValid && $stable(rxByte)) else $error("rx byte lost while stalled");
  a_uplink_pulse: assert property (uplinkRxNibbleValid |=> !uplinkRxNibbleValid)
    else $error("uplink valid not a pulse");
  a_pin_clock: assert property (!uplinkLampSelect |=>
    uplinkTxClockOrLamp == mgmtPortTxClock) else $error("shared pin not tx clock");
  a_pin_lamp: assert property (uplinkLampSelect |=>
    uplinkTxClockOrLamp == !$past(lampFifteenOn)) else $error("lamp 15 not active low");
endmodule : rgmii_port_pins_checker

bind rgmii_port_pins rgmii_port_pins_checker chk_u (.sys_clk, .rst, .speedMode, .mgmtPortTxClock,
  .mgmtPortTxData, .mgmtPortTxEnable, .rxByte, .rxByteValid, .rxByteReady, .txByte, .txByteValid,
  .txByteReady, .uplinkRxNibbleValid, .uplinkLampSelect, .lampFifteenOn, .uplinkTxClockOrLamp,
  .lampFiveOn, .lampFiveIn, .lampFiveOut, .lampFiveOe, .refclkFreqStrap);

`default_nettype wire

// ---- verif/rgmii_link_partner.sv ----
`timescale 1ns/100ps
`default_nettype none

module rgmii_link_partner
(
  output logic       rxClock,
  output logic [3:0] rxData,
  output logic       rxValid
);
  // idle link: clock stands still and the pulled-down lines sit low
  initial
  begin
    rxClock = 1'h0;
    rxData  = 4'h0;
    rxValid = 1'h0;
  end

  // one byte, low nibble first; data moves on the opposite edge at 10/100 and midway between the edges at gigabit, so it is centred
  task automatic sendByte(input logic [7:0] b, input bit gig, input bit vld);
    rxValid = vld; // valid follows our own transmit enable
    rxData  = b[3:0];
    if (gig)
    begin
      // same 400 ns period at gigabit; data moves midway between the edges
      #100;
      rxClock = 1'h1; // low nibble taken here
      #100;
      rxData  = b[7:4];
      #100;
      rxClock = 1'h0; // high nibble taken here
      #100;
    end
    else
    begin
      #200;
      rxClock = 1'h1;
      #200;
      rxClock = 1'h0; // 400 ns period, the 10M rate
      rxData  = b[7:4];
      #200;
      rxClock = 1'h1;
      #200;
      rxClock = 1'h0;
    end
  endtask : sendByte

  // released lines fall to the pull-down level, never hold the last value
  task automatic endFrame;
    rxValid = 1'h0;
    rxData  = 4'h0;
  endtask : endFrame
endmodule : rgmii_link_partner

`default_nettype wire

// ---- verif/rgmii_port_pins_tb_top.sv ----
`timescale 1ns/100ps
`default_nettype none

`define CHK(nm, e, g) \
  begin \
    nChecks++; \
    if ((g) !== (e)) \
    begin \
      errors++; \
      $display("unexpected %s expected %h seen %h", nm, e, g); \
    end \
  end

module rgmii_port_pins_tb_top;
  import rgmii_port_pkg::*;
  logic       sys_clk, rst, strapLevel, mgmtPortRxClock, mgmtPortRxValid, mgmtPortTxClock;
  logic       mgmtPortTxEnable, rxByteValid, rxByteReady, rxOverrun, txByteValid, txByteReady;
  logic       uplinkRxClock, uplinkRxValid, uplinkRxNibbleValid, uplinkLampSelect, lampFifteenOn;
  logic       uplinkTxClockOrLamp, lampFiveOn, lampFiveIn, lampFiveOut, lampFiveOe;
  logic       refclkFreqStrap;
  logic [3:0] mgmtPortRxData, mgmtPortTxData, uplinkRxData, uplinkRxNibble;
  logic [7:0] rxByte, txByte;
  logic [3:0] upNibs[$];
  speed_t     speedMode;
  int         errors, nChecks, overruns;

  rgmii_port_pins dut_u (.sys_clk, .rst, .speedMode, .mgmtPortRxClock, .mgmtPortRxData,
    .mgmtPortRxValid, .mgmtPortTxClock, .mgmtPortTxData, .mgmtPortTxEnable, .rxByte,
    .rxByteValid, .rxByteReady, .rxOverrun, .txByte, .txByteValid, .txByteReady,
    .uplinkRxClock, .uplinkRxData, .uplinkRxValid, .uplinkRxNibble, .uplinkRxNibbleValid,
    .uplinkLampSelect, .lampFifteenOn, .uplinkTxClockOrLamp, .lampFiveOn, .lampFiveIn,
    .lampFiveOut, .lampFiveOe, .refclkFreqStrap);
  rgmii_link_partner mgmtPeer (.rxClock(mgmtPortRxClock), .rxData(mgmtPortRxData),
    .rxValid(mgmtPortRxValid));
  rgmii_link_partner uplinkPeer (.rxClock(uplinkRxClock), .rxData(uplinkRxData),
    .rxValid(uplinkRxValid));

  // strap pin: board level until the device starts driving it
  assign lampFiveIn = lampFiveOe ? lampFiveOut : strapLevel;

  // 20 MHz system clock
  initial
  begin
    sys_clk = 1'h0;
    forever #25 sys_clk = ~sys_clk;
  end

  // one-cycle pulses are gathered mid-cycle, away from the edge that launches them
  always @(negedge sys_clk)
  begin
    if (rxOverrun === 1'h1)
      overruns++;
    if (uplinkRxNibbleValid === 1'h1)
      upNibs.push_back(uplinkRxNibble);
  end

  task automatic conclude;
    if (errors == 0 && nChecks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : conclude

  // speed only changes under reset, so no clock period is cut mid-way
  task automatic resetTo(input speed_t s, input logic strap);
    rst = 1'h1;
    speedMode = s;
    strapLevel = strap;
    repeat (3) @(posedge sys_clk);
    #1 rst = 1'h0;
    repeat (20) @(posedge sys_clk);
    #1;
    `CHK("strap", strap, refclkFreqStrap)
  endtask : resetTo

  // a spare cycle after the release keeps a following pop off the same time step
  task automatic popByte;
    rxByteReady = 1'h1;
    @(posedge sys_clk);
    #1 rxByteReady = 1'h0;
    @(posedge sys_clk);
    #1;
  endtask : popByte

  task automatic settle;
    repeat (8) @(posedge sys_clk);
    #1;
  endtask : settle

  // three bytes into a stalled two-entry buffer, then an unqualified byte
  task automatic rxTest;
    mgmtPeer.sendByte(8'h5A, 1'h0, 1'h1);
    mgmtPeer.sendByte(8'hC3, 1'h0, 1'h1);
    mgmtPeer.sendByte(8'h7E, 1'h0, 1'h1);
    mgmtPeer.endFrame();
    settle();
    `CHK("overruns", 1, overruns)
    `CHK("rx byte 0", 8'h5A, rxByte)
    popByte();
    `CHK("rx byte 1", 8'hC3, rxByte)
    popByte();
    `CHK("rx empty", 1'h0, rxByteValid)
    mgmtPeer.sendByte(8'h11, 1'h0, 1'h0);
    settle();
    `CHK("rx unqualified", 1'h0, rxByteValid)
  endtask : rxTest

  task automatic rxGigTest;
    mgmtPeer.sendByte(8'hB4, 1'h1, 1'h1);
    mgmtPeer.endFrame();
    settle();
    `CHK("rx gig byte", 8'hB4, rxByte)
    popByte();
  endtask : rxGigTest

  // uplink nibbles, then the shared pin and the lamp five pin
  task automatic uplinkTest;
    uplinkPeer.sendByte(8'hE1, 1'h0, 1'h1);
    uplinkPeer.endFrame();
    settle();
    `CHK("uplink nibbles", 8'hE1, {upNibs[1], upNibs[0]})
    `CHK("uplink count", 2, upNibs.size())
    uplinkLampSelect = 1'h1;
    lampFifteenOn = 1'h1;
    lampFiveOn = 1'h0;
    settle();
    `CHK("lamp 15 pin", 1'h0, uplinkTxClockOrLamp)
    `CHK("lamp 5 pin", 1'h1, lampFiveIn)
    uplinkLampSelect = 1'h0;
    settle();
    `CHK("shared clock", mgmtPortTxClock, uplinkTxClockOrLamp)
    // half a 10M period later the clock is in its other phase, so a stuck pin shows
    repeat (4) @(posedge sys_clk);
    #1;
    `CHK("shared clock late", mgmtPortTxClock, uplinkTxClockOrLamp)
  endtask : uplinkTest

  // offer one byte and follow it nibble by nibble at the transmit clock
  task automatic txTest(input logic [7:0] b, input bit gig);
    int guard;
    txByte = b;
    txByteValid = 1'h1;
    guard = 0;
    do
    begin
      @(negedge sys_clk);
      guard++;
    end
    while (txByteReady !== 1'h1 && guard < 40);
    `CHK("tx ready", 1'h1, txByteReady)
    @(posedge sys_clk);
    #1 txByteValid = 1'h0;
    `CHK("tx low", {2'h3, b[3:0]}, {mgmtPortTxEnable, mgmtPortTxClock, mgmtPortTxData})
    if (gig)
      @(posedge sys_clk);
    else
      @(posedge mgmtPortTxClock);
    #1;
    `CHK("tx high", b[7:4], mgmtPortTxData)
    @(posedge mgmtPortTxClock);
    #1;
    `CHK("tx enable end", 1'h0, mgmtPortTxEnable)
  endtask : txTest

  initial
  begin
    {rst, strapLevel, rxByteReady, txByteValid, uplinkLampSelect, lampFifteenOn} = 6'h20;
    speedMode = SPEED_10;
    txByte = 8'h00;
    lampFiveOn = 1'h1;
    @(posedge sys_clk);
    #1;
    resetTo(SPEED_10, 1'h1);
    rxTest();
    uplinkTest();
    txTest(8'hA5, 1'h0);
    resetTo(SPEED_100, 1'h0);
    txTest(8'h69, 1'h0);
    resetTo(SPEED_1000, 1'h0);
    txTest(8'h3C, 1'h1);
    rxGigTest();
    conclude();
  end

  // watchdog well beyond the roughly twelve microseconds the run needs
  initial
  begin
    #200000;
    errors++;
    conclude();
  end
endmodule : rgmii_port_pins_tb_top

`default_nettype wire
